// ---- hdl/lsp_host_port.sv ----
// parallel host port, registers and segment data path of the segment driver
`timescale 1ns/1ps
`default_nettype none
module lsp_host_port
  import lsp_pkg::*;
#(
  parameter int unsigned BUSY_CYC = LSP_BUSY_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two_n,
  input wire logic chip_select_three,
  input wire logic enable_strobe,
  input wire logic read_not_write,
  input wire logic register_select,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic reset_in_n,
  input wire logic column_dir,
  input wire logic frame_start,
  input wire logic row_latch_pulse,
  output logic [LSP_COLS-1:0] seg_on,
  output logic [LSP_COLS-1:0] seg_blank,
  output logic [LSP_LINE_W-1:0] line_count
);
  import lsp_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int unsigned SW = 10;
  logic [SW-1:0] pin_s;
  logic [7:0] bus_s;
  lsp_sync #(.W(SW)) u_sync_ctl (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({chip_select_one_n, chip_select_two_n, chip_select_three, enable_strobe,
               read_not_write, register_select, reset_in_n, column_dir, frame_start,
               row_latch_pulse}),
    .sync_out(pin_s)
  );
  lsp_sync #(.W(8)) u_sync_bus (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(bus_in),
    .sync_out(bus_s)
  );
  logic cs1_n, cs2_n, cs3, en_s, rnw_s, rs_s, rstn_s, dir_s, frm_s, cl_s;
  assign {cs1_n, cs2_n, cs3, en_s, rnw_s, rs_s, rstn_s, dir_s, frm_s, cl_s} = pin_s;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lsp_state_t st_r, st_nxt;
  logic en_d_r, en_d_nxt;
  logic cl_d_r, cl_d_nxt;
  logic [7:0] in_r, in_nxt;
  logic [7:0] out_r, out_nxt;
  logic [7:0] bus_r, bus_nxt;
  logic oe_r, oe_nxt;
  logic off_r, off_nxt;
  logic off_pend_r, off_pend_nxt;
  logic [LSP_PAGE_W-1:0] page_r, page_nxt;
  logic [LSP_COL_W-1:0] col_r, col_nxt;
  logic [LSP_LINE_W-1:0] start_r, start_nxt;
  logic [LSP_LINE_W-1:0] line_r, line_nxt;
  logic [LSP_COL_W-1:0] scan_col_r, scan_col_nxt;
  logic [LSP_COLS-1:0] seg_r, seg_nxt;
  logic [LSP_COLS-1:0] blank_r, blank_nxt;
  logic [LSP_COLS-1:0] seg_on_r, seg_on_nxt;
  logic [7:0] rd_data, scan_data;
  logic ram_we;
  logic ram_we_d_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic sel, busy, in_reset, fall, rise;
  logic [7:0] status;
  assign sel = !cs1_n && !cs2_n && cs3;
  assign in_reset = !rstn_s;
  assign busy = (st_r != LSP_IDLE);
  assign fall = en_d_r && !en_s;
  assign rise = !en_d_r && en_s;
  always_comb
  begin
    status = 8'h00;
    status[LSP_ST_BUSY] = busy;
    status[LSP_ST_OFF] = off_r;
    status[LSP_ST_RST] = in_reset;
  end

  lsp_ram u_ram (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(ram_we),
    .addr({page_r, col_r}),
    .wr_data(in_r),
    .rd_data(rd_data),
    .scan_addr({line_r[LSP_PAGE_W+2:3], scan_col_r}),
    .scan_data(scan_data)
  );

  // ------------------------------------------------------------
  // host access engine
  // ------------------------------------------------------------
  logic [7:0] busy_cnt_r, busy_cnt_nxt;
  always_comb
  begin
    st_nxt = st_r;
    en_d_nxt = en_s;
    in_nxt = in_r;
    out_nxt = out_r;
    off_pend_nxt = off_pend_r;
    page_nxt = page_r;
    col_nxt = col_r;
    start_nxt = start_r;
    busy_cnt_nxt = busy_cnt_r;
    ram_we = 1'b0;
    case (st_r)
      LSP_IDLE:
      begin
        if (sel && fall && !in_reset)
        begin
          if (rs_s && !rnw_s)
          begin
            in_nxt = bus_s;
            st_nxt = LSP_WR;
          end
          else if (rs_s && rnw_s)
            st_nxt = LSP_RD;
          else if (!rs_s && !rnw_s)
          begin
            if (bus_s[7:1] == LSP_OP_ONOFF)
              off_pend_nxt = !bus_s[0];
            else if (bus_s[7:6] == LSP_OP_COL)
              col_nxt = bus_s[5:0];
            else if (bus_s[7:3] == LSP_OP_PAGE)
              page_nxt = bus_s[2:0];
            else if (bus_s[7:6] == LSP_OP_LINE)
              start_nxt = bus_s[5:0];
          end
        end
      end
      LSP_WR:
      begin
        ram_we = 1'b1;
        col_nxt = col_r + 6'h01;
        busy_cnt_nxt = 8'(BUSY_CYC);
        st_nxt = LSP_HOLD;
      end
      LSP_RD:
      begin
        busy_cnt_nxt = 8'(BUSY_CYC);
        st_nxt = LSP_HOLD;
      end
      LSP_HOLD:
      begin
        if (busy_cnt_r == 8'h01)
          st_nxt = LSP_IDLE;
        else
          busy_cnt_nxt = busy_cnt_r - 8'h01;
        // ram read data valid one cycle after address; take it once
        if (busy_cnt_r == 8'(BUSY_CYC) && !ram_we_d_r)
        begin
          out_nxt = rd_data;
          col_nxt = col_r + 6'h01;
        end
      end
      default: st_nxt = LSP_IDLE;
    endcase
    if (in_reset)
    begin
      start_nxt = LSP_LINE_RST;
      off_pend_nxt = LSP_OFF_RST;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r <= LSP_IDLE;
      en_d_r <= 1'b0;
      in_r <= 8'h00;
      out_r <= 8'h00;
      off_pend_r <= LSP_OFF_RST;
      page_r <= '0;
      col_r <= '0;
      start_r <= LSP_LINE_RST;
      busy_cnt_r <= 8'h00;
      ram_we_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      en_d_r <= en_d_nxt;
      in_r <= in_nxt;
      out_r <= out_nxt;
      off_pend_r <= off_pend_nxt;
      page_r <= page_nxt;
      col_r <= col_nxt;
      start_r <= start_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      ram_we_d_r <= ram_we;
    end
  end

  // ------------------------------------------------------------
  // bus driver: status or output register while enable is high
  // ------------------------------------------------------------
  always_comb
  begin
    bus_nxt = bus_r;
    oe_nxt = oe_r;
    if (sel && rnw_s && rise)
    begin
      oe_nxt = 1'b1;
      // data reads show the byte fetched by the previous read
      bus_nxt = rs_s ? out_r : status;
    end
    if (!en_s)
      oe_nxt = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bus_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_r <= bus_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ------------------------------------------------------------
  // display on/off flip-flop and line counter
  // ------------------------------------------------------------
  always_comb
  begin
    cl_d_nxt = cl_s;
    off_nxt = off_r;
    line_nxt = line_r;
    if (in_reset)
      off_nxt = 1'b1;
    else if (cl_s && !cl_d_r)
    begin
      off_nxt = off_pend_r;
      line_nxt = line_r + 6'h01;
    end
    if (frm_s)
      line_nxt = start_r;
    blank_nxt = {LSP_COLS{off_nxt}};
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cl_d_r <= 1'b0;
      off_r <= LSP_OFF_RST;
      line_r <= LSP_LINE_RST;
      blank_r <= '1;
    end
    else if (clk_en)
    begin
      cl_d_r <= cl_d_nxt;
      off_r <= off_nxt;
      line_r <= line_nxt;
      blank_r <= blank_nxt;
    end
  end

  // ------------------------------------------------------------
  // segment scan: one column per cycle from display ram
  // ------------------------------------------------------------
  always_comb
  begin
    scan_col_nxt = scan_col_r + 6'h01;
    seg_nxt = seg_r;
    // ram answers one cycle after its address: data is for the previous column
    for (int i = 0; i < LSP_COLS; i++)
    begin
      if (6'(i) == scan_col_r - 6'h01)
      begin
        if (dir_s)
          seg_nxt[i] = scan_data[line_r[2:0]];
        else
          seg_nxt[LSP_COLS-1-i] = scan_data[line_r[2:0]];
      end
    end
    seg_on_nxt = seg_nxt & ~blank_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      scan_col_r <= '0;
      seg_r <= '0;
      seg_on_r <= '0;
    end
    else if (clk_en)
    begin
      scan_col_r <= scan_col_nxt;
      seg_r <= seg_nxt;
      seg_on_r <= seg_on_nxt;
    end
  end

  assign bus_out = bus_r;
  assign bus_oe = oe_r;
  assign seg_on = seg_on_r;
  assign seg_blank = blank_r;
  assign line_count = line_r;
endmodule // lsp_host_port
`default_nettype wire

// ---- hdl/lsp_ram.sv ----
// display ram, one byte per page and column
`timescale 1ns/1ps
`default_nettype none
module lsp_ram
  import lsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [LSP_PAGE_W+LSP_COL_W-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [LSP_PAGE_W+LSP_COL_W-1:0] scan_addr,
  output logic [7:0] scan_data
);
  logic [7:0] mem [0:LSP_PAGES*LSP_COLS-1];
  logic [7:0] rd_r;
  logic [7:0] scan_r;

  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        mem[addr] <= wr_data;
      rd_r <= mem[addr];
      scan_r <= mem[scan_addr];
    end
  end

  assign rd_data = rd_r;
  assign scan_data = scan_r;
endmodule // lsp_ram
`default_nettype wire

// ---- hdl/lsp_sync.sv ----
// two-flop synchroniser, one per input bit
`timescale 1ns/1ps
`default_nettype none
module lsp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule // lsp_sync
`default_nettype wire

// ---- shared/lsp_pkg.sv ----
// package of constants and types for the lcd segment host port
package lsp_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int unsigned LSP_COLS = 64;
  localparam int unsigned LSP_PAGES = 8;
  localparam int unsigned LSP_COL_W = 6;
  localparam int unsigned LSP_PAGE_W = 3;
  localparam int unsigned LSP_LINE_W = 6;
  // ------------------------------------------------------------
  // instruction decode patterns
  // ------------------------------------------------------------
  localparam logic [6:0] LSP_OP_ONOFF = 7'h1f;
  localparam logic [1:0] LSP_OP_COL = 2'h1;
  localparam logic [4:0] LSP_OP_PAGE = 5'h17;
  localparam logic [1:0] LSP_OP_LINE = 2'h3;
  // ------------------------------------------------------------
  // status byte fields
  // ------------------------------------------------------------
  localparam int unsigned LSP_ST_BUSY = 7;
  localparam int unsigned LSP_ST_OFF = 5;
  localparam int unsigned LSP_ST_RST = 4;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] LSP_LINE_RST = 6'h00;
  localparam logic LSP_OFF_RST = 1'b1;
  // ------------------------------------------------------------
  // timing: internal ram transfer, in clock cycles
  // ------------------------------------------------------------
  localparam int unsigned LSP_CLK_MHZ = 250;
  localparam int unsigned LSP_BUSY_NS = 8;
  localparam int unsigned LSP_BUSY_CYC = (LSP_BUSY_NS * LSP_CLK_MHZ + 999) / 1000;
  // ------------------------------------------------------------
  // engine states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    LSP_IDLE = 4'h1,
    LSP_WR = 4'h2,
    LSP_RD = 4'h4,
    LSP_HOLD = 4'h8
  } lsp_state_t;
endpackage

// ---- tb/lsp_host_port_props.sv ----
// concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
module lsp_host_port_props
  import lsp_pkg::*;
#(
  parameter int unsigned BUSY_CYC = LSP_BUSY_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two_n,
  input wire logic chip_select_three,
  input wire logic enable_strobe,
  input wire logic read_not_write,
  input wire logic register_select,
  input wire logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic reset_in_n,
  input wire logic column_dir,
  input wire logic frame_start,
  input wire logic row_latch_pulse,
  input wire logic [LSP_COLS-1:0] seg_on,
  input wire logic [LSP_COLS-1:0] seg_blank,
  input wire logic [LSP_LINE_W-1:0] line_count
);
  logic sel;
  assign sel = !chip_select_one_n && !chip_select_two_n && chip_select_three;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_rst_low;
    (!reset_in_n) [*4];
  endsequence
  sequence s_stat_rd;
    (sel && enable_strobe && read_not_write && !register_select && !reset_in_n) [*5];
  endsequence
  a_read_oe_cause: assert property ($rose(bus_oe) |->
    $past(enable_strobe, 3) && $past(read_not_write, 3) && $past(sel, 3))
    else $error("bus driven without a selected read");
  a_oe_release: assert property ($fell(enable_strobe) |-> ##[1:5] !bus_oe)
    else $error("bus still driven after enable fell");
  a_desel_quiet: assert property ((!sel) [*6] |-> !bus_oe)
    else $error("bus driven while not selected");
  a_status_rst_bits: assert property (s_rst_low ##1 s_stat_rd |->
    bus_oe && bus_out[6:0] == 7'h30) else $error("status in reset wrong");
  a_rst_blank: assert property (s_rst_low |-> seg_on == '0 && &seg_blank)
    else $error("segments show data in reset");
  a_blank_uniform: assert property ((seg_blank == '0 || seg_blank == '1) &&
    (seg_on & seg_blank) == '0) else $error("blanking not uniform");
  a_blank_on_latch: assert property ((!row_latch_pulse && reset_in_n) [*8] |->
    $stable(seg_blank)) else $error("display state moved without latch pulse");
  a_line_on_latch: assert property ((!row_latch_pulse && !frame_start) [*8] |->
    $stable(line_count)) else $error("line counter moved without latch pulse");
endmodule // lsp_host_port_props
bind lsp_host_port lsp_host_port_props #(.BUSY_CYC(BUSY_CYC)) u_lsp_host_port_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .chip_select_one_n(chip_select_one_n), .chip_select_two_n(chip_select_two_n),
  .chip_select_three(chip_select_three), .enable_strobe(enable_strobe),
  .read_not_write(read_not_write), .register_select(register_select), .bus_in(bus_in),
  .bus_out(bus_out), .bus_oe(bus_oe), .reset_in_n(reset_in_n), .column_dir(column_dir),
  .frame_start(frame_start), .row_latch_pulse(row_latch_pulse), .seg_on(seg_on),
  .seg_blank(seg_blank), .line_count(line_count)
);
`default_nettype wire

// ---- tb/lsp_mpu_model.sv ----
// host processor model for the parallel port
`timescale 1ns/1ps
`default_nettype none
module lsp_mpu_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  output logic chip_select_one_n,
  output logic chip_select_two_n,
  output logic chip_select_three,
  output logic enable_strobe,
  output logic read_not_write,
  output logic register_select,
  output logic [7:0] bus_in
);
  int ph = 8;
  initial
  begin
    {chip_select_three, chip_select_two_n, chip_select_one_n} = 3'h3;
    enable_strobe = 1'b0;
    read_not_write = 1'b1;
    register_select = 1'b0;
    bus_in = 8'h00;
  end
  // one bus stroke; cs is {three, two_n, one_n}
  task automatic stroke(input logic [2:0] cs, input logic rs, input logic rd,
    input logic [7:0] wd, output logic [7:0] q, output logic oe);
    @(posedge core_clk);
    #1;
    {chip_select_three, chip_select_two_n, chip_select_one_n} = cs;
    register_select = rs;
    read_not_write = rd;
    bus_in = rd ? ~bus_in : wd;
    repeat (3) @(posedge core_clk);
    #1 enable_strobe = 1'b1;
    repeat (ph) @(posedge core_clk);
    #1 q = bus_out;
    oe = bus_oe;
    enable_strobe = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 bus_in = ~bus_in;
    repeat (ph) @(posedge core_clk);
    #1;
  endtask
  task automatic poll(output logic ok);
    logic [7:0] s;
    logic oe;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++)
    begin
      stroke(3'h4, 1'b0, 1'b1, 8'h00, s, oe);
      ok = oe === 1'b1 && s[7] === 1'b0 && s[4] === 1'b0;
    end
  endtask
endmodule // lsp_mpu_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the lcd segment host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_in_n = 1'b1;
  logic column_dir = 1'b1;
  logic frame_start = 1'b0;
  logic row_latch_pulse = 1'b0;
  logic cs1_n, cs2_n, cs3, en, rnw, rs, bus_oe;
  logic [7:0] bus_in, bus_out;
  logic [63:0] seg_on, seg_blank;
  logic [5:0] line_count;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  lsp_host_port #(.BUSY_CYC(60)) u_lsp_host_port (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .chip_select_one_n(cs1_n), .chip_select_two_n(cs2_n), .chip_select_three(cs3),
    .enable_strobe(en), .read_not_write(rnw), .register_select(rs), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .reset_in_n(reset_in_n), .column_dir(column_dir),
    .frame_start(frame_start), .row_latch_pulse(row_latch_pulse), .seg_on(seg_on),
    .seg_blank(seg_blank), .line_count(line_count)
  );
  lsp_mpu_model u_mpu (
    .core_clk(core_clk), .bus_out(bus_out), .bus_oe(bus_oe), .chip_select_one_n(cs1_n),
    .chip_select_two_n(cs2_n), .chip_select_three(cs3), .enable_strobe(en),
    .read_not_write(rnw), .register_select(rs), .bus_in(bus_in)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic rs_v, input logic rd_v, input logic [7:0] d,
    output logic [7:0] q);
    logic oe;
    logic ok;
    u_mpu.stroke(3'h4, rs_v, rd_v, d, q, oe);
    u_mpu.poll(ok);
    chk(ok, 1'b1);
  endtask
  task automatic cl_pulse(input logic f);
    frame_start = f;
    row_latch_pulse = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 row_latch_pulse = 1'b0;
    frame_start = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_pin();
    logic [7:0] s;
    logic oe;
    chk(bus_oe, 1'b0);
    chk(line_count, 6'h00);
    chk(seg_on, 64'h0);
    chk(seg_blank, '1);
    u_mpu.stroke(3'h3, 1'b0, 1'b1, 8'h00, s, oe);
    chk(oe, 1'b0);
    reset_in_n = 1'b0;
    repeat (4) @(posedge core_clk);
    u_mpu.stroke(3'h4, 1'b0, 1'b0, 8'h3f, s, oe);
    u_mpu.stroke(3'h4, 1'b0, 1'b1, 8'h00, s, oe);
    chk({oe, s[6:0]}, 8'hb0);
    reset_in_n = 1'b1;
    u_mpu.poll(oe);
    chk(oe, 1'b1);
    cl_pulse(1'b0);
    u_mpu.stroke(3'h4, 1'b0, 1'b1, 8'h00, s, oe);
    chk(s, 8'h20);
    chk(seg_blank, '1);
  endtask
  task automatic t_rw();
    logic [7:0] q;
    logic oe;
    op(1'b0, 1'b0, 8'hba, q);
    op(1'b0, 1'b0, 8'h45, q);
    u_mpu.stroke(3'h4, 1'b1, 1'b0, 8'ha5, q, oe);
    u_mpu.stroke(3'h4, 1'b0, 1'b1, 8'h00, q, oe);
    chk(q[7], 1'b1);
    op(1'b1, 1'b0, 8'h77, q);
    op(1'b1, 1'b0, 8'h3c, q);
    op(1'b0, 1'b0, 8'h45, q);
    for (int i = 0; i < 3; i++)
    begin
      u_mpu.stroke(3'h4 ^ (3'h1 << i), 1'b1, 1'b0, 8'hff, q, oe);
      u_mpu.stroke(3'h4 ^ (3'h1 << i), 1'b0, 1'b0, 8'h40, q, oe);
    end
    u_mpu.ph = 20;
    op(1'b1, 1'b1, 8'h00, q);
    op(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'ha5);
    op(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h3c);
    u_mpu.ph = 8;
  endtask
  task automatic t_display();
    logic [7:0] q;
    logic oe;
    op(1'b0, 1'b0, 8'hb9, q);
    op(1'b0, 1'b0, 8'h40, q);
    for (int i = 0; i < 64; i++)
      op(1'b1, 1'b0, (i == 0) ? 8'h01 : 8'h00, q);
    op(1'b0, 1'b0, 8'hc8, q);
    op(1'b0, 1'b0, 8'h3f, q);
    chk(seg_blank, '1);
    cl_pulse(1'b1);
    chk(line_count, 6'h08);
    chk(seg_blank, 64'h0);
    repeat (70) @(posedge core_clk);
    #1;
    chk(seg_on, 64'h1);
    column_dir = 1'b0;
    repeat (70) @(posedge core_clk);
    #1;
    chk(seg_on, 64'h8000_0000_0000_0000);
    op(1'b0, 1'b0, 8'hc5, q);
    reset_in_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(seg_blank, '1);
    chk(seg_on, 64'h0);
    reset_in_n = 1'b1;
    u_mpu.poll(oe);
    chk(oe, 1'b1);
    cl_pulse(1'b1);
    chk(line_count, 6'h00);
    chk(seg_blank, '1);
    op(1'b0, 1'b0, 8'h3f, q);
    cl_pulse(1'b0);
    chk(seg_blank, 64'h0);
    op(1'b0, 1'b0, 8'h3e, q);
    cl_pulse(1'b0);
    chk(seg_on, 64'h0);
    chk(seg_blank, '1);
    u_mpu.stroke(3'h4, 1'b0, 1'b1, 8'h00, q, oe);
    chk(q, 8'h20);
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    t_reset_pin();
    t_rw();
    t_display();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
